// file: design/conv_ctrl.sv
// Converter control: start, accumulation, window compare, flags and sleep
module conv_ctrl (
  // Clock and reset
  input  wire logic                         SYS_CLK,
  input  wire logic                         NRST,
  // Configuration
  input  wire logic                         ENABLE,
  input  wire logic                         FREE_RUN,
  input  wire logic                         EIGHT_BIT_MODE,
  input  wire logic [2:0]                   SAMPLE_COUNT,
  input  wire logic [1:0]                   VREF_CHOICE,
  input  wire logic                         HOLD_CAPACITOR_CHOICE,
  input  wire logic [4:0]                   INPUT_CHANNEL,
  input  wire logic [2:0]                   POWER_UP_WAIT,
  input  wire logic                         KEEP_ALIVE_IN_STANDBY,
  input  wire logic                         EVENT_TRIGGER_ENABLE,
  // Window setup
  input  wire logic [2:0]                   WINDOW_COMPARE_SELECT,
  input  wire logic [15:0]                  WINDOW_FLOOR,
  input  wire logic [15:0]                  WINDOW_CEILING,
  // Interrupt enables and flag clears
  input  wire logic [1:0]                   IRQ_ENABLE,
  input  wire logic [1:0]                   FLAG_CLEAR,
  // Commands and events
  input  wire logic                         CONVERT_GO_WRITE,
  input  wire logic                         EVENT_IN,
  input  wire logic                         VALUE_READ,
  // Sleep state
  input  wire conv_ctrl_pkg::sleep_mode_t   SLEEP_MODE,
  // Analog core
  input  wire conv_ctrl_pkg::analog_result_t ANALOG_RESULT,
  output conv_ctrl_pkg::analog_ctrl_t       ANALOG_CTRL,
  // Status
  output logic                              CONVERT_GO_BIT,
  output logic [15:0]                       CONVERSION_VALUE,
  output logic                              VALUE_VALID,
  output logic [1:0]                        IRQ_FLAGS,
  output logic [1:0]                        IRQ_REQUEST,
  output logic                              CLOCK_REQUEST
);
  import conv_ctrl_pkg::*;

  // Samples per conversion from the accumulation field
  // The reserved setting folds to a single sample
  function automatic logic [6:0] samples_of(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > MAX_SAMPLE_COUNT) ? 3'h0 : sel;
    samples_of = 7'(7'h01 << s);
  endfunction : samples_of

  // Sequencer
  conv_state_t  state;
  conv_state_t  next_state;

  // Start edge and standby settling
  logic         event_seen;
  logic         in_standby;
  logic         init_pending;

  // Sample bookkeeping
  logic         busy;
  logic         invalid;
  logic [6:0]   sample_idx;
  logic [15:0]  acc;
  logic [11:0]  wait_cnt;

  // Window strobe and its value
  logic         finish_d;
  logic [15:0]  finish_value;

  // Sleep and start terms
  wire logic        standby;
  wire logic        powerdown;
  wire logic        running;
  wire logic        event_rise;
  wire logic        sw_start;
  wire logic        start_req;
  wire logic        need_wait;
  wire logic        wait_done;

  // Sample path
  wire logic        sample_done;
  wire logic        last_sample;
  wire logic        finish;
  wire logic [9:0]  sat_code;
  wire logic [9:0]  res_code;
  wire logic [15:0] acc_sum;
  wire logic [11:0] wait_load;

  // Window, flags and reference
  wire logic        win_hit;
  wire logic [1:0]  flag_set;
  wire logic [1:0]  flag_clr;
  wire logic [1:0]  next_flags;
  wire logic        use_supply;

  // Sleep qualifiers
  assign standby   = SLEEP_MODE == SLEEP_STANDBY;
  assign powerdown = SLEEP_MODE == SLEEP_POWERDOWN;
  // Converter on: enabled, and in standby only when kept alive
  // Idle sleep counts as active here
  assign running   = ENABLE && (!standby || KEEP_ALIVE_IN_STANDBY);

  // Start sources
  // Software writes are ignored in standby; events still start
  assign event_rise = EVENT_IN && !event_seen;
  assign sw_start   = CONVERT_GO_WRITE && !standby;
  assign start_req  = running && !powerdown &&
                      ((event_rise && EVENT_TRIGGER_ENABLE) ||
                       sw_start);
  assign wait_load  = 12'(POWER_UP_WAIT) * 12'(WAIT_STEP_CYCLES);
  assign need_wait  = init_pending && (POWER_UP_WAIT != 3'h0);
  assign wait_done  = wait_cnt == 12'h000;

  // Sample handling
  // Eight-bit mode drops the two low bits before accumulating
  assign sample_done = (state == ST_CONVERT) && busy && ANALOG_RESULT.done;
  assign sat_code    = ANALOG_RESULT.over_ref ? FULL_SCALE_CODE
                                              : ANALOG_RESULT.code;
  assign res_code    = EIGHT_BIT_MODE ? {2'b00, sat_code[9:2]} : sat_code;
  assign acc_sum     = acc + {6'h00, res_code};
  assign last_sample = sample_idx == (samples_of(SAMPLE_COUNT) - 7'h01);
  assign finish      = sample_done && last_sample;

  // Reference choice: reserved codes fall back to the internal source
  // The core takes a new choice while idle or as a free run restarts
  assign use_supply = VREF_CHOICE == VREF_SUPPLY;

  // Sequencer next state
  // Completion outranks power-down so a finished single run never halts
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = need_wait ? ST_WAIT : ST_CONVERT;
        end
      end
      ST_WAIT: begin
        if (!running) begin
          next_state = ST_IDLE;
        end else if (wait_done) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!running) begin
          next_state = ST_IDLE;
        end else if (finish && !FREE_RUN) begin
          next_state = ST_IDLE;
        end else if (powerdown) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (!ENABLE) begin
          next_state = ST_IDLE;
        end else if (!powerdown) begin
          next_state = ST_CONVERT;
        end
      end
    endcase
  end

  // State register
  // Gray codes keep each step between neighbours along idle, wait, convert, halt a single-bit change
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Edge detect and standby entry tracking
  // Resets low, the idle level of the event line, so no false edge
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      event_seen <= 1'b0;
      in_standby <= 1'b0;
    end else begin
      event_seen <= EVENT_IN;
      in_standby <= standby;
    end
  end

  // First conversion after standby activation waits for settling
  // Only a fresh entry into standby arms the wait
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      init_pending <= 1'b0;
    end else if (standby && !in_standby) begin
      init_pending <= 1'b1;
    end else if (!standby || (state == ST_IDLE && start_req)) begin
      init_pending <= 1'b0;
    end
  end

  // Power-up wait counter
  // Reloaded while idle so a changed wait field is taken fresh
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wait_cnt <= 12'h000;
    end else if (state == ST_IDLE) begin
      wait_cnt <= wait_load;
    end else if (state == ST_WAIT && !wait_done) begin
      wait_cnt <= wait_cnt - 12'h001;
    end
  end

  // Go bit: set on start, cleared on completion or when stopped
  // Follows the next state so it rises at the accepting edge
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CONVERT_GO_BIT <= 1'b0;
    end else begin
      CONVERT_GO_BIT <= next_state != ST_IDLE;
    end
  end

  // Sample in flight to the analog core
  // Kept across a halt so the resumed run launches no second sample;
  // an answer taken in the halting cycle still retires it
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      busy <= 1'b0;
    end else if (next_state != ST_CONVERT) begin
      busy <= busy && !sample_done && (next_state == ST_HALT);
    end else if (sample_done) begin
      busy <= 1'b0;
    end else if (!busy && state == ST_CONVERT) begin
      busy <= 1'b1;
    end
  end

  // Accumulator and sample index, cleared at each new conversion
  // The last sample goes straight from the sum into the result
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      acc        <= VALUE_RESET;
      sample_idx <= 7'h00;
    end else if (state != ST_CONVERT && state != ST_HALT) begin
      acc        <= VALUE_RESET;
      sample_idx <= 7'h00;
    end else if (finish) begin
      acc        <= VALUE_RESET;
      sample_idx <= 7'h00;
    end else if (sample_done) begin
      acc        <= acc_sum;
      sample_idx <= sample_idx + 7'h01;
    end
  end

  // A halt inside a conversion spoils its value
  // Cleared at the end or in idle, so a halt in any sample taints it
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      invalid <= 1'b0;
    end else if (state == ST_HALT) begin
      invalid <= 1'b1;
    end else if (finish || state == ST_IDLE) begin
      invalid <= 1'b0;
    end
  end

  // Result capture
  // Taken from the sum so the last sample is included
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CONVERSION_VALUE <= VALUE_RESET;
      VALUE_VALID      <= 1'b0;
    end else if (finish) begin
      CONVERSION_VALUE <= acc_sum;
      VALUE_VALID      <= !invalid;
    end
  end

  // Window compare strobe follows the final sample by one cycle
  // Registering the sum keeps the compare off the adder path
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      finish_d     <= 1'b0;
      finish_value <= VALUE_RESET;
    end else begin
      finish_d     <= finish && (WINDOW_COMPARE_SELECT != WIN_OFF);
      finish_value <= acc_sum;
    end
  end

  // Window compare on the settled sum
  window_check #(
    .WIDTH   (VALUE_BITS)
  ) u_window (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .STROBE  (finish_d),
    .VALUE   (finish_value),
    .MODE    (WINDOW_COMPARE_SELECT),
    .FLOOR   (WINDOW_FLOOR),
    .CEILING (WINDOW_CEILING),
    .HIT     (win_hit)
  );

  // Flag set and clear terms; a set in the clearing cycle wins
  // That way no completion goes unflagged
  assign flag_set   = {win_hit, finish};
  assign flag_clr   = FLAG_CLEAR | {1'b0, VALUE_READ};
  assign next_flags = (IRQ_FLAGS & ~flag_clr) | flag_set;

  // Flags and requests; vector order ready then window
  // Requests rise with the flag and fall with its clear
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ_FLAGS   <= 2'b00;
      IRQ_REQUEST <= 2'b00;
    end else begin
      IRQ_FLAGS   <= next_flags;
      IRQ_REQUEST <= next_flags & IRQ_ENABLE;
    end
  end

  // Peripheral clock wanted in standby only while waiting or converting
  // Dropped with the last sample so the clock can be gated at once
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      CLOCK_REQUEST <= 1'b0;
    end else begin
      CLOCK_REQUEST <= standby && (next_state != ST_IDLE);
    end
  end

  // Analog controls; channel and reference track until a start locks them
  // Locking keeps a held sample on one input and one reference
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ANALOG_CTRL <= '0;
    end else begin
      ANALOG_CTRL.start   <= (state == ST_CONVERT) && !busy &&
                             (next_state == ST_CONVERT);
      ANALOG_CTRL.halt    <= next_state == ST_HALT;
      ANALOG_CTRL.powered <= running;
      if (state == ST_IDLE || (finish && next_state == ST_CONVERT)) begin
        ANALOG_CTRL.use_supply <= use_supply;
        ANALOG_CTRL.channel    <= INPUT_CHANNEL;
        ANALOG_CTRL.sensor_on  <= INPUT_CHANNEL == SENSOR_CHANNEL;
        ANALOG_CTRL.hold_cap   <= HOLD_CAPACITOR_CHOICE;
      end
    end
  end

endmodule : conv_ctrl

// file: design/window_check.sv
// Window comparator with registered hit pulse
module window_check #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic                       SYS_CLK,
  input  wire logic                       NRST,
  // Compare request
  input  wire logic                       STROBE,
  input  wire logic [WIDTH-1:0]           VALUE,
  input  wire logic [2:0]                 MODE,
  input  wire logic [WIDTH-1:0]           FLOOR,
  input  wire logic [WIDTH-1:0]           CEILING,
  // Result
  output logic                            HIT
);
  import conv_ctrl_pkg::*;

  wire logic below;
  wire logic above;
  wire logic match;

  // Strict unsigned tests on the whole value
  assign below = VALUE < FLOOR;
  assign above = VALUE > CEILING;
  assign match = (MODE == WIN_BELOW)   ? below :
                 (MODE == WIN_ABOVE)   ? above :
                 (MODE == WIN_INSIDE)  ? (VALUE > FLOOR) && (VALUE < CEILING) :
                 (MODE == WIN_OUTSIDE) ? below || above :
                 1'b0;              // Off and reserved codes never hit

  // One pulse per matching compare strobe
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      HIT <= 1'b0;
    end else begin
      HIT <= STROBE && match;
    end
  end

endmodule : window_check

// file: shared/conv_ctrl_pkg.sv
// Constants, modes and carriers shared by the converter control block
package conv_ctrl_pkg;

  localparam int          CODE_BITS        = 10;
  localparam int          VALUE_BITS       = 16;
  localparam logic [9:0]  FULL_SCALE_CODE  = 10'h3FF;
  localparam logic [1:0]  VREF_INTERNAL    = 2'h0;
  localparam logic [1:0]  VREF_SUPPLY      = 2'h1;
  localparam logic [4:0]  SENSOR_CHANNEL   = 5'h1E;
  localparam logic [7:0]  VECTOR_READY     = 8'h00;
  localparam logic [7:0]  VECTOR_WINDOW    = 8'h02;
  localparam int          FLAG_READY       = 0;
  localparam int          FLAG_WINDOW      = 1;
  localparam logic [2:0]  MAX_SAMPLE_COUNT = 3'h6;
  localparam logic [15:0] VALUE_RESET      = 16'h0000;
  // Power-up wait: one step of the field is this long, in converter clocks
  localparam int          WAIT_STEP_CONV_CLOCKS = 16;
  localparam int          CONV_CLOCK_NS         = 100;
  localparam int          SYS_CLOCK_NS          = 50;
  localparam int          WAIT_STEP_CYCLES      =
    (WAIT_STEP_CONV_CLOCKS * CONV_CLOCK_NS + SYS_CLOCK_NS - 1) / SYS_CLOCK_NS;

  // Window compare modes
  typedef enum logic [2:0] {
    WIN_OFF     = 3'h0,
    WIN_BELOW   = 3'h1,
    WIN_ABOVE   = 3'h2,
    WIN_INSIDE  = 3'h3,
    WIN_OUTSIDE = 3'h4
  } window_mode_t;

  // Device sleep state
  typedef enum logic [1:0] {
    SLEEP_ACTIVE    = 2'h0,
    SLEEP_IDLE      = 2'h1,
    SLEEP_STANDBY   = 2'h2,
    SLEEP_POWERDOWN = 2'h3
  } sleep_mode_t;

  // Sequencer states, Gray coded along idle, wait, convert, halt
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_WAIT    = 2'b01,
    ST_CONVERT = 2'b11,
    ST_HALT    = 2'b10
  } conv_state_t;

  // Controls sent to the analog core
  typedef struct packed {
    logic       start;
    logic       halt;
    logic       powered;
    logic       use_supply;
    logic       sensor_on;
    logic       hold_cap;
    logic [4:0] channel;
  } analog_ctrl_t;

  // Answer from the analog core
  typedef struct packed {
    logic       done;
    logic       over_ref;
    logic [9:0] code;
  } analog_result_t;

endpackage : conv_ctrl_pkg

// file: verification/analog_core_model.sv
// Analog core model: answers each start pulse with one sample after a latency
module analog_core_model (
  // Clock and reset
  input  wire logic                         SYS_CLK,
  input  wire logic                         NRST,
  // Controls and the sample to hand back
  input  wire conv_ctrl_pkg::analog_ctrl_t  ANALOG_CTRL,
  input  wire logic [9:0]                   SAMPLE_CODE,
  input  wire logic                         OVER_REF,
  input  wire logic [7:0]                   LATENCY,
  // Answer
  output conv_ctrl_pkg::analog_result_t     ANALOG_RESULT
);
  timeunit 1ns;
  timeprecision 1ns;
  import conv_ctrl_pkg::*;

  logic       busy;
  logic [7:0] count;

  // One sample in flight; halt freezes it, the code line holds the sample only in the done cycle
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      busy          <= 1'b0;
      count         <= 8'h00;
      ANALOG_RESULT <= '0;
    end else begin
      ANALOG_RESULT.done <= 1'b0;
      ANALOG_RESULT.code <= ~ANALOG_RESULT.code;
      if (ANALOG_CTRL.start) begin
        busy  <= 1'b1;
        count <= LATENCY;
      end else if (busy && !ANALOG_CTRL.halt) begin
        count <= count - 8'h01;
        if (count == 8'h00) begin
          busy                   <= 1'b0;
          ANALOG_RESULT.done     <= 1'b1;
          ANALOG_RESULT.over_ref <= OVER_REF;
          ANALOG_RESULT.code     <= SAMPLE_CODE;
        end
      end
    end
  end
endmodule : analog_core_model

// file: verification/conv_ctrl_monitor.sv
// Checker that watches the converter control ports
module conv_ctrl_monitor (
  // Clock and reset
  input wire logic                          SYS_CLK,
  input wire logic                          NRST,
  // Inputs that qualify the checks
  input wire logic [1:0]                    IRQ_ENABLE,
  input wire logic [1:0]                    FLAG_CLEAR,
  input wire logic                          VALUE_READ,
  input wire logic                          KEEP_ALIVE_IN_STANDBY,
  input wire logic [2:0]                    WINDOW_COMPARE_SELECT,
  input wire conv_ctrl_pkg::sleep_mode_t    SLEEP_MODE,
  input wire conv_ctrl_pkg::analog_result_t ANALOG_RESULT,
  // Outputs under watch
  input wire conv_ctrl_pkg::analog_ctrl_t   ANALOG_CTRL,
  input wire logic                          CONVERT_GO_BIT,
  input wire logic [1:0]                    IRQ_FLAGS,
  input wire logic [1:0]                    IRQ_REQUEST
);
  timeunit 1ns;
  timeprecision 1ns;
  import conv_ctrl_pkg::*;

  // All checks run on the system clock and rest in reset
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  // A fresh go bit in active mode brings the start pulse one cycle later
  property p_go_start;
    $rose(CONVERT_GO_BIT) && SLEEP_MODE == SLEEP_ACTIVE |=> ANALOG_CTRL.start;
  endproperty
  a_go_start: assert property (p_go_start) else $error("no start after go");

  // Ready flag stays until a clear or a read
  property p_sticky;
    IRQ_FLAGS[0] && !FLAG_CLEAR[0] && !VALUE_READ |=> IRQ_FLAGS[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("ready flag lost");

  // Enabled and flagged ready source raises its request next cycle
  property p_req;
    IRQ_FLAGS[0] && IRQ_ENABLE[0] && !FLAG_CLEAR[0] && !VALUE_READ |=> IRQ_REQUEST[0];
  endproperty
  a_req: assert property (p_req) else $error("ready request missing");

  // No window request without the window flag
  property p_no_req;
    !IRQ_FLAGS[1] |-> !IRQ_REQUEST[1];
  endproperty
  a_no_req: assert property (p_no_req) else $error("window request without flag");

  // A read with no sample answer clears the ready flag
  property p_read_clear;
    VALUE_READ && !ANALOG_RESULT.done |=> !IRQ_FLAGS[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read left flag set");

  // Window flag only rises while a mode is selected
  property p_win_sel;
    $rose(IRQ_FLAGS[1]) |-> WINDOW_COMPARE_SELECT != 3'h0;
  endproperty
  a_win_sel: assert property (p_win_sel) else $error("window flag while off");

  // Sensor power goes with the sensor channel
  property p_sensor;
    ANALOG_CTRL.sensor_on == (ANALOG_CTRL.channel == SENSOR_CHANNEL);
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor power mismatch");

  // No sample start during power-down
  property p_pd_halt;
    (SLEEP_MODE == SLEEP_POWERDOWN) [*3] |-> !ANALOG_CTRL.start;
  endproperty
  a_pd_halt: assert property (p_pd_halt) else $error("start in power-down");

  // Standby without keep-alive leaves the converter stopped
  property p_stby_off;
    (SLEEP_MODE == SLEEP_STANDBY && !KEEP_ALIVE_IN_STANDBY) [*3] |-> !CONVERT_GO_BIT;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("busy in standby");
endmodule : conv_ctrl_monitor

bind conv_ctrl conv_ctrl_monitor mon (.SYS_CLK, .NRST, .IRQ_ENABLE, .FLAG_CLEAR, .VALUE_READ,
  .KEEP_ALIVE_IN_STANDBY, .WINDOW_COMPARE_SELECT, .SLEEP_MODE, .ANALOG_RESULT, .ANALOG_CTRL,
  .CONVERT_GO_BIT, .IRQ_FLAGS, .IRQ_REQUEST);

// file: verification/tb_top.sv
// Self-checking bench of the converter control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import conv_ctrl_pkg::*;

  // Stimulus and observed signals
  logic [1:0]  VREF_CHOICE = 2'h0, IRQ_ENABLE = 2'h0, FLAG_CLEAR = 2'h0;
  logic [2:0]  SAMPLE_COUNT = 3'h0, POWER_UP_WAIT = 3'h0, WINDOW_COMPARE_SELECT = 3'h0;
  logic [4:0]  INPUT_CHANNEL = 5'h00;
  logic [15:0] WINDOW_FLOOR = 16'h0000, WINDOW_CEILING = 16'h0000, CONVERSION_VALUE;
  logic        SYS_CLK = 1'b0, NRST = 1'b0, ENABLE = 1'b1, FREE_RUN = 1'b0;
  logic        EIGHT_BIT_MODE = 1'b0, HOLD_CAPACITOR_CHOICE = 1'b0;
  logic        KEEP_ALIVE_IN_STANDBY = 1'b0, EVENT_TRIGGER_ENABLE = 1'b0;
  logic        CONVERT_GO_WRITE = 1'b0, EVENT_IN = 1'b0, VALUE_READ = 1'b0, over_ref = 1'b0;
  logic        CONVERT_GO_BIT, VALUE_VALID, CLOCK_REQUEST;
  logic [1:0]  IRQ_FLAGS, IRQ_REQUEST;
  logic [9:0]  sample_code = 10'h000;
  logic [7:0]  latency = 8'h03;
  sleep_mode_t    SLEEP_MODE = SLEEP_ACTIVE;
  analog_result_t ANALOG_RESULT;
  analog_ctrl_t   ANALOG_CTRL;
  int          n_errors = 0;
  int          checks_done = 0;

  // Design and analog core
  conv_ctrl uut (.SYS_CLK, .NRST, .ENABLE, .FREE_RUN, .EIGHT_BIT_MODE, .SAMPLE_COUNT,
    .VREF_CHOICE, .HOLD_CAPACITOR_CHOICE, .INPUT_CHANNEL, .POWER_UP_WAIT,
    .KEEP_ALIVE_IN_STANDBY, .EVENT_TRIGGER_ENABLE, .WINDOW_COMPARE_SELECT, .WINDOW_FLOOR,
    .WINDOW_CEILING, .IRQ_ENABLE, .FLAG_CLEAR, .CONVERT_GO_WRITE, .EVENT_IN, .VALUE_READ,
    .SLEEP_MODE, .ANALOG_RESULT, .ANALOG_CTRL, .CONVERT_GO_BIT, .CONVERSION_VALUE,
    .VALUE_VALID, .IRQ_FLAGS, .IRQ_REQUEST, .CLOCK_REQUEST);
  analog_core_model core (.SYS_CLK, .NRST, .ANALOG_CTRL, .SAMPLE_CODE(sample_code),
    .OVER_REF(over_ref), .LATENCY(latency), .ANALOG_RESULT);

  // 20 MHz clock
  always #25 SYS_CLK = ~SYS_CLK;

  // Pass n rising edges and land just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge SYS_CLK);
    #5;
  endtask : step

  // Compare one value and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Clear flags, then start by a write or by an event edge
  task automatic launch(input logic ev);
    FLAG_CLEAR = 2'h3;
    step(1);
    FLAG_CLEAR = 2'h0;
    EVENT_IN = ev;
    CONVERT_GO_WRITE = !ev;
    step(1);
    EVENT_IN = 1'b0;
    CONVERT_GO_WRITE = 1'b0;
  endtask : launch

  // Wait for the ready flag, then let the window flag settle
  task automatic wait_ready;
    int i;
    for (i = 0; i < 600 && IRQ_FLAGS[0] !== 1'b1; i++) step(1);
    chk(IRQ_FLAGS[0], 1'b1);
    step(3);
  endtask : wait_ready

  // One full conversion of a given code
  task automatic convert(input logic [9:0] code, input logic ev);
    sample_code = code;
    launch(ev);
    wait_ready();
  endtask : convert

  // Result value, reference choice, sensor channel, request and read clear
  task automatic t_result;
    VREF_CHOICE = 2'h1;
    INPUT_CHANNEL = SENSOR_CHANNEL;
    POWER_UP_WAIT = 3'h7;
    IRQ_ENABLE = 2'h1;
    convert(10'h123, 1'b0);
    chk(CONVERSION_VALUE, 16'h0123);
    chk(CONVERT_GO_BIT, 1'b0);
    chk(IRQ_REQUEST, 2'h1);
    chk(ANALOG_CTRL.use_supply, 1'b1);
    chk(ANALOG_CTRL.sensor_on, 1'b1);
    chk(ANALOG_CTRL.channel, SENSOR_CHANNEL);
    VALUE_READ = 1'b1;
    step(1);
    VALUE_READ = 1'b0;
    chk(IRQ_FLAGS[0], 1'b0);
    step(1);
    chk(IRQ_REQUEST, 2'h0);
    VREF_CHOICE = 2'h2;
    INPUT_CHANNEL = 5'h03;
    POWER_UP_WAIT = 3'h0;
    over_ref = 1'b1;
    convert(10'h155, 1'b0);
    over_ref = 1'b0;
    chk(CONVERSION_VALUE, 16'h03FF);
    chk(ANALOG_CTRL.use_supply, 1'b0);
    chk(ANALOG_CTRL.sensor_on, 1'b0);
    $display("t_result done");
  endtask : t_result

  // Every window mode against codes at the floor, between and beyond the limits
  task automatic t_window;
    logic [9:0] codes [4];
    logic       hit;
    codes = '{10'h100, 10'h180, 10'h250, 10'h050};
    WINDOW_FLOOR = 16'h0100;
    WINDOW_CEILING = 16'h0200;
    VREF_CHOICE = 2'h0;
    IRQ_ENABLE = 2'h0;
    for (int m = 0; m < 6; m++) begin
      WINDOW_COMPARE_SELECT = m[2:0];
      IRQ_ENABLE = {m[0], 1'b0};
      foreach (codes[k]) begin
        hit = (m == 1 && codes[k] < 10'h100) || (m == 2 && codes[k] > 10'h200)
          || (m == 3 && codes[k] > 10'h100 && codes[k] < 10'h200)
          || (m == 4 && (codes[k] < 10'h100 || codes[k] > 10'h200));
        convert(codes[k], 1'b0);
        chk(IRQ_FLAGS[1], hit);
        chk(IRQ_REQUEST, {hit && m[0], 1'b0});
      end
    end
    chk(ANALOG_CTRL.use_supply, 1'b0);
    SAMPLE_COUNT = 3'h2;
    WINDOW_COMPARE_SELECT = 3'h1;
    WINDOW_FLOOR = 16'h0150;
    IRQ_ENABLE = 2'h2;
    convert(10'h100, 1'b0);
    chk(CONVERSION_VALUE, 16'h0400);
    chk(IRQ_FLAGS[1], 1'b0);
    SAMPLE_COUNT = 3'h0;
    WINDOW_COMPARE_SELECT = 3'h0;
    $display("t_window done");
  endtask : t_window

  // Event start with and without the trigger enable
  task automatic t_event;
    launch(1'b1);
    step(2);
    chk(CONVERT_GO_BIT, 1'b0);
    EVENT_TRIGGER_ENABLE = 1'b1;
    sample_code = 10'h2A5;
    launch(1'b1);
    chk(CONVERT_GO_BIT, 1'b1);
    wait_ready();
    chk(CONVERT_GO_BIT, 1'b0);
    chk(CONVERSION_VALUE, 16'h02A5);
    EIGHT_BIT_MODE = 1'b1;
    convert(10'h2A5, 1'b1);
    EIGHT_BIT_MODE = 1'b0;
    chk(CONVERSION_VALUE, 16'h00A9);
    FREE_RUN = 1'b1;
    convert(10'h044, 1'b0);
    chk(CONVERT_GO_BIT, 1'b1);
    FREE_RUN = 1'b0;
    VALUE_READ = 1'b1;
    step(1);
    VALUE_READ = 1'b0;
    wait_ready();
    chk(CONVERT_GO_BIT, 1'b0);
    $display("t_event done");
  endtask : t_event

  // Standby: refused without keep-alive, delayed event start with it
  task automatic t_standby;
    int i;
    SLEEP_MODE = SLEEP_STANDBY;
    launch(1'b0);
    step(4);
    chk(CONVERT_GO_BIT, 1'b0);
    chk(ANALOG_CTRL.powered, 1'b0);
    KEEP_ALIVE_IN_STANDBY = 1'b1;
    POWER_UP_WAIT = 3'h1;
    launch(1'b1);
    for (i = 0; i < 100 && ANALOG_CTRL.start !== 1'b1; i++) step(1);
    chk(i >= 32, 1'b1);
    chk(CLOCK_REQUEST, 1'b1);
    wait_ready();
    chk(VALUE_VALID, 1'b1);
    chk(CLOCK_REQUEST, 1'b0);
    SLEEP_MODE = SLEEP_ACTIVE;
    KEEP_ALIVE_IN_STANDBY = 1'b0;
    POWER_UP_WAIT = 3'h0;
    $display("t_standby done");
  endtask : t_standby

  // Power-down in mid-conversion halts it; ready still comes, value invalid
  task automatic t_powerdown;
    latency = 8'h14;
    launch(1'b0);
    step(4);
    SLEEP_MODE = SLEEP_POWERDOWN;
    step(40);
    chk(IRQ_FLAGS[0], 1'b0);
    chk(CONVERT_GO_BIT, 1'b1);
    chk(ANALOG_CTRL.halt, 1'b1);
    SLEEP_MODE = SLEEP_ACTIVE;
    wait_ready();
    chk(VALUE_VALID, 1'b0);
    latency = 8'h03;
    convert(10'h011, 1'b0);
    chk(VALUE_VALID, 1'b1);
    $display("t_powerdown done");
  endtask : t_powerdown

  // Counts, verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run
  initial begin
    #3000000;
    n_errors++;
    end_sim();
  end

  // Reset for 16 cycles, then the scenarios
  initial begin
    step(16);
    NRST = 1'b1;
    step(2);
    t_result();
    t_window();
    t_event();
    t_standby();
    t_powerdown();
    end_sim();
  end
endmodule : tb_top
